// ==== core/fault_per_channel_fault_regs_pkg.sv ====
// package: shared constants and carriers for the switch fault diagnostic block
`default_nettype none
package fault_per_channel_fault_regs_pkg;
    localparam int unsigned NUM_CH          = 4;
    // summary register bit positions
    localparam int unsigned SUM_LINK_LOSS   = 7;
    localparam int unsigned SUM_OT_SHUTDOWN = 6;
    localparam int unsigned SUM_SUPPLY_HI   = 5;
    localparam int unsigned SUM_SUPPLY_LO   = 4;
    localparam logic [7:0]  SUMMARY_RESET   = 8'h00;
    // diagnostic index inside mask / clear vectors
    localparam int unsigned PER_CHANNEL_FAULT_REGS_W          = 12;
    localparam int unsigned PER_CHANNEL_FAULT_REGS_OC_BASE    = 0;   // bits 3:0 overcurrent per channel
    localparam int unsigned PER_CHANNEL_FAULT_REGS_OT_BASE    = 4;   // bits 7:4 overheat constraint per channel
    localparam int unsigned PER_CHANNEL_FAULT_REGS_GLOBAL_OVERHEAT_SHUTDOWN      = 8;
    localparam int unsigned PER_CHANNEL_FAULT_REGS_SUP_OS     = 9;
    localparam int unsigned PER_CHANNEL_FAULT_REGS_SUP_LOW    = 10;
    localparam int unsigned PER_CHANNEL_FAULT_REGS_LINK       = 11;
    // default masks: faults (constraint/shutdown) drive the pin, warnings do not
    localparam logic [11:0] FAULT_MASK_DEFAULT = 12'hbff;
    localparam logic [11:0] AUTO_CLR_DEFAULT   = 12'hfff;
    // settling time before a changed raw condition is reported
    localparam int unsigned SETTLE_NS       = 1000;
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W        = $clog2(SETTLE_CYCLES + 1);

    // raw analog comparator levels as seen by the logic
    typedef struct packed {
        logic             link_lost;
        logic             logic_supply_low;
        logic             field_supply_over;
        logic             field_supply_low;
        logic             field_supply_under;
        logic [NUM_CH-1:0] overheat;
        logic [NUM_CH-1:0] overcurrent;
    } raw_cond_s;

    // consequences applied to the switch
    typedef struct packed {
        logic [NUM_CH-1:0] channel_on;
        logic             low_clamp;
    } out_ctrl_s;
endpackage
`default_nettype wire

// ==== core/settle_filter.sv ====
// module: two-flop synchroniser plus settle filter for one raw condition bit
`default_nettype none
module settle_filter
    import fault_per_channel_fault_regs_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    input  wire logic i_raw,
    output logic      o_settled
);
    logic                sync_a;
    logic                sync_b;
    logic [SETTLE_W-1:0] count;

    // the first stage feeds only the second stage
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= i_raw;
            sync_b <= sync_a;
        end
    end

    // a new level must hold for the full settle time; brief swings restart the count
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            count     <= '0;
            o_settled <= 1'b0;
        end else if (sync_b == o_settled) begin
            count <= '0;
        end else if (count == SETTLE_W'(SETTLE_CYCLES - 1)) begin
            count     <= '0;
            o_settled <= sync_b;
        end else begin
            count <= count + SETTLE_W'(1);
        end
    end
endmodule
`default_nettype wire

// ==== core/report_latch.sv ====
// module: one diagnostic report with automatic or host-requested clearing
`default_nettype none
module report_latch (
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    input  wire logic i_cond,
    input  wire logic i_auto_clear,
    input  wire logic i_clear_req,
    output logic      o_report
);
    // a live condition always wins over any clear, so nothing is lost
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_report <= 1'b0;
        end else if (i_cond) begin
            o_report <= 1'b1;
        end else if (i_auto_clear || i_clear_req) begin
            o_report <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== core/switch_fault_per_channel_fault_regs_reporting.sv ====
// module: diagnostic reporting and fault consequences for a four-channel switch
`default_nettype none
// Overview of operation
// - supply change reported only after settling
// - unpowered field supply sets link-loss bit 7
// - field supply bits sit at summary [5:4]
// - bit 5 flags overvoltage or undervoltage shutdown
// - bit 4 warns on low or undervoltage
// - two-bit field distinguishes four supply states
// - logic supply undervoltage: outputs off, fault on
// - fault pin mask has default, host reconfigurable
// - warnings alone do not assert the fault pin under the default mask
// - one channel overheated: flag, off, low clamp
// - all overheated: global shutdown, all off
// - overheat change reported only after settling
// - overcurrent reported only while channel commanded on
// - overcurrent: flag, channel off, others run
// - channel one maps to bit zero
// - clamp change applies to all channels together
// - fault pin on when any masked report true
// - non-auto reports hold until host clear
module switch_fault_per_channel_fault_regs_reporting
    import fault_per_channel_fault_regs_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    input  wire raw_cond_s         i_raw,
    input  wire logic [NUM_CH-1:0] i_switch_on_command_bits,
    input  wire logic              i_fault_mask_load,
    input  wire logic [PER_CHANNEL_FAULT_REGS_W-1:0] i_fault_pin_mask,
    input  wire logic              i_auto_clear_load,
    input  wire logic [PER_CHANNEL_FAULT_REGS_W-1:0] i_auto_clear_mask,
    input  wire logic [PER_CHANNEL_FAULT_REGS_W-1:0] i_report_clear_request,
    output logic [7:0]             o_global_fault_summary,
    output logic [NUM_CH-1:0]      o_channel_overheat_constraint,
    output logic [NUM_CH-1:0]      o_channel_overcurrent_shutdown,
    output out_ctrl_s              o_out_ctrl,
    output logic                   o_fault_indicator_pin_out,
    output logic                   o_fault_indicator_pin_oe
);
    localparam int unsigned RAW_W = $bits(raw_cond_s);

    raw_cond_s         settled;
    logic [NUM_CH-1:0] cmd_sync_a;
    logic [NUM_CH-1:0] cmd_sync;
    logic [PER_CHANNEL_FAULT_REGS_W-1:0] fault_mask;
    logic [PER_CHANNEL_FAULT_REGS_W-1:0] auto_clear;
    logic [PER_CHANNEL_FAULT_REGS_W-1:0] cond;
    logic [PER_CHANNEL_FAULT_REGS_W-1:0] report;
    logic              supply_hi;
    logic              supply_lo;
    logic              ot_all;
    logic              fault_any;

    // every raw condition is synchronised and settled before use
    for (genvar b = 0; b < RAW_W; b++) begin : g_filter
        settle_filter u_filter (
            .i_ref_clk (i_ref_clk),
            .i_reset   (i_reset),
            .i_raw     (i_raw[b]),
            .o_settled (settled[b])
        );
    end

    // channel commands arrive from pins, so they pass two flops
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cmd_sync_a <= '0;
            cmd_sync   <= '0;
        end else begin
            cmd_sync_a <= i_switch_on_command_bits;
            cmd_sync   <= cmd_sync_a;
        end
    end

    // fault pin mask: default set until the host loads another
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            fault_mask <= FAULT_MASK_DEFAULT;
        end else if (i_fault_mask_load) begin
            fault_mask <= i_fault_pin_mask;
        end
    end

    // automatic clear mask, all automatic after reset
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            auto_clear <= AUTO_CLR_DEFAULT;
        end else if (i_auto_clear_load) begin
            auto_clear <= i_auto_clear_mask;
        end
    end

    // supply state: over -> 10, low -> 01, under -> 11
    assign supply_hi = settled.field_supply_over | settled.field_supply_under;
    assign supply_lo = settled.field_supply_low | settled.field_supply_under;
    assign ot_all    = &settled.overheat;

    // live conditions; bit n of each channel group is channel n+1
    always_comb begin
        cond = '0;
        // a channel commanded low never reports overcurrent
        cond[PER_CHANNEL_FAULT_REGS_OC_BASE +: NUM_CH] = settled.overcurrent & cmd_sync;
        cond[PER_CHANNEL_FAULT_REGS_OT_BASE +: NUM_CH] = settled.overheat;
        cond[PER_CHANNEL_FAULT_REGS_GLOBAL_OVERHEAT_SHUTDOWN]             = ot_all;
        cond[PER_CHANNEL_FAULT_REGS_SUP_OS]            = supply_hi;
        cond[PER_CHANNEL_FAULT_REGS_SUP_LOW]           = supply_lo;
        // an unpowered field side also looks like a lost link
        cond[PER_CHANNEL_FAULT_REGS_LINK]              = settled.link_lost | settled.field_supply_under;
    end

    // one latch per diagnostic; held reports wait for the host clear
    for (genvar d = 0; d < PER_CHANNEL_FAULT_REGS_W; d++) begin : g_report
        report_latch u_latch (
            .i_ref_clk    (i_ref_clk),
            .i_reset      (i_reset),
            .i_cond       (cond[d]),
            .i_auto_clear (auto_clear[d]),
            .i_clear_req  (i_report_clear_request[d]),
            .o_report     (report[d])
        );
    end

    // summary and per-channel flags come straight from report flops
    always_comb begin
        o_global_fault_summary                  = SUMMARY_RESET;
        o_global_fault_summary[SUM_LINK_LOSS]   = report[PER_CHANNEL_FAULT_REGS_LINK];
        o_global_fault_summary[SUM_OT_SHUTDOWN] = report[PER_CHANNEL_FAULT_REGS_GLOBAL_OVERHEAT_SHUTDOWN];
        o_global_fault_summary[SUM_SUPPLY_HI]   = report[PER_CHANNEL_FAULT_REGS_SUP_OS];
        o_global_fault_summary[SUM_SUPPLY_LO]   = report[PER_CHANNEL_FAULT_REGS_SUP_LOW];
    end
    assign o_channel_overheat_constraint  = report[PER_CHANNEL_FAULT_REGS_OT_BASE +: NUM_CH];
    assign o_channel_overcurrent_shutdown = report[PER_CHANNEL_FAULT_REGS_OC_BASE +: NUM_CH];

    // fault pin: masked reports, warning bit excluded by default mask
    // logic supply undervoltage drives the pin regardless of mask
    assign fault_any = (|(report & fault_mask)) | settled.logic_supply_low;

    // consequences use live conditions so outputs recover when the cause
    // goes, except the link loss which also waits for its report to clear
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_out_ctrl                <= '0;
            o_fault_indicator_pin_oe  <= 1'b0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                o_out_ctrl.channel_on[c] <= cmd_sync[c]
                    & ~cond[PER_CHANNEL_FAULT_REGS_OC_BASE + c]
                    & ~settled.overheat[c]
                    & ~ot_all
                    & ~settled.field_supply_under
                    & ~settled.logic_supply_low
                    & ~cond[PER_CHANNEL_FAULT_REGS_LINK] & ~report[PER_CHANNEL_FAULT_REGS_LINK];
            end
            // one clamp select shared by every channel
            o_out_ctrl.low_clamp <= (|settled.overheat) | settled.field_supply_over;
            o_fault_indicator_pin_oe <= fault_any;
        end
    end

    // open drain: only ever pulls low
    assign o_fault_indicator_pin_out = 1'b0;
endmodule
`default_nettype wire

// ==== bench/fault_per_channel_fault_regs_chk.sv ====
// checker: timing relations between diagnostic reports, pin and outputs
`default_nettype none
module fault_per_channel_fault_regs_chk
    import fault_per_channel_fault_regs_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    input  wire raw_cond_s         i_raw,
    input  wire logic              i_fault_mask_load,
    input  wire logic [PER_CHANNEL_FAULT_REGS_W-1:0] i_fault_pin_mask,
    input  wire logic [7:0]        o_global_fault_summary,
    input  wire logic [NUM_CH-1:0] o_channel_overheat_constraint,
    input  wire logic [NUM_CH-1:0] o_channel_overcurrent_shutdown,
    input  wire out_ctrl_s         o_out_ctrl,
    input  wire logic              o_fault_indicator_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PER_CHANNEL_FAULT_REGS_W-1:0] mask;
    logic [PER_CHANNEL_FAULT_REGS_W-1:0] per_channel_fault_regs;
    logic [7:0]        sm;
    logic [NUM_CH-1:0] ot;
    logic [NUM_CH-1:0] oc;
    // mirror of the pin mask, so pin checks follow host reconfiguration
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) mask <= FAULT_MASK_DEFAULT;
        else if (i_fault_mask_load) mask <= i_fault_pin_mask;
    end
    // reports gathered in mask bit order
    assign sm = o_global_fault_summary;
    assign ot = o_channel_overheat_constraint;
    assign oc = o_channel_overcurrent_shutdown;
    assign per_channel_fault_regs = {sm[7], sm[4], sm[5], sm[6], ot, oc};
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    property p_sd_all; sm[6] |-> &ot; endproperty
    a_sd_all: assert property (p_sd_all) else $error("shutdown without all constraints");
    // reports and outputs are loaded on the same edge from the same settled levels, so
    // they are compared in one cycle; a cycle later the outputs already follow the cause
    property p_out_off; (sm[7] || sm[6] || sm[5:4] == 2'b11) |-> o_out_ctrl.channel_on == '0;
    endproperty
    a_out_off: assert property (p_out_off) else $error("outputs left on");
    property p_os_clamp; sm[5:4] == 2'b10 |-> o_out_ctrl.low_clamp; endproperty
    a_os_clamp: assert property (p_os_clamp) else $error("no low clamp on overvoltage");
    property p_ot_off; |ot |-> o_out_ctrl.low_clamp && (o_out_ctrl.channel_on & ot) == '0;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("hot channel on");
    property p_oc_off; |oc |-> (o_out_ctrl.channel_on & oc) == '0; endproperty
    a_oc_off: assert property (p_oc_off) else $error("overloaded channel on");
    property p_pin_on; |(per_channel_fault_regs & mask) |=> o_fault_indicator_pin_oe; endproperty
    a_pin_on: assert property (p_pin_on) else $error("fault pin not driven");
    property p_pin_why;
        $rose(o_fault_indicator_pin_oe) |-> $past(|(per_channel_fault_regs & mask)) || i_raw.logic_supply_low;
    endproperty
    a_pin_why: assert property (p_pin_why) else $error("fault pin without cause");
    property p_under_link; sm[5:4] == 2'b11 |-> sm[7]; endproperty
    a_under_link: assert property (p_under_link) else $error("no link loss on under");
    property p_sup_settle;
        $rose(sm[5]) |-> $past(i_raw.field_supply_over, 150) || $past(i_raw.field_supply_under, 150);
    endproperty
    a_sup_settle: assert property (p_sup_settle) else $error("supply report too early");
    property p_ot_settle; $rose(ot[1]) |-> $past(i_raw.overheat[1], 150); endproperty
    a_ot_settle: assert property (p_ot_settle) else $error("overheat report too early");
    c_ot_all: cover property (sm[6]);
    c_link: cover property (sm[7]);
    c_oc: cover property (|oc);
endmodule
bind switch_fault_per_channel_fault_regs_reporting fault_per_channel_fault_regs_chk u_fault_per_channel_fault_regs_chk (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_raw(i_raw), .i_fault_mask_load(i_fault_mask_load),
    .i_fault_pin_mask(i_fault_pin_mask), .o_global_fault_summary(o_global_fault_summary),
    .o_channel_overheat_constraint(o_channel_overheat_constraint),
    .o_channel_overcurrent_shutdown(o_channel_overcurrent_shutdown),
    .o_out_ctrl(o_out_ctrl), .o_fault_indicator_pin_oe(o_fault_indicator_pin_oe));
`default_nettype wire

// ==== bench/host_model.sv ====
// host model: pulled-up fault line and one-cycle clear writes
`default_nettype none
module host_model
    import fault_per_channel_fault_regs_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_pin_oe,
    input  wire logic              i_pin_out,
    input  wire logic              i_clear_go,
    input  wire logic [PER_CHANNEL_FAULT_REGS_W-1:0] i_clear_bits,
    output logic                   o_pin_level,
    output logic [PER_CHANNEL_FAULT_REGS_W-1:0]      o_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    // open drain with pull-up: a released line reads high
    assign o_pin_level = i_pin_oe ? i_pin_out : 1'b1;
    initial o_clear = '0;
    // a clear write lasts one cycle and changes off the sampling edge
    always @(negedge i_ref_clk) begin
        o_clear <= i_clear_go ? i_clear_bits : '0;
    end
endmodule
`default_nettype wire

// ==== bench/switch_fault_per_channel_fault_regs_reporting_bench.sv ====
// bench: scenario sequences for the fault diagnostic block
`default_nettype none
module switch_fault_per_channel_fault_regs_reporting_bench
    import fault_per_channel_fault_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    raw_cond_s         raw = '0;
    logic [NUM_CH-1:0] cmd = 4'hf;
    logic              mload = 1'b0, aload = 1'b0, go = 1'b0, pin_out, pin_oe, pin;
    logic [PER_CHANNEL_FAULT_REGS_W-1:0] mval = '0, aval = '0, cbits = '0, clr;
    logic [7:0]        sm;
    logic [NUM_CH-1:0] ot, oc;
    out_ctrl_s         ctl;
    logic [2:0]        sup [4] = '{3'h0, 3'h2, 3'h4, 3'h3};
    int                mismatches = 0, n_tests = 0, cyc = 0;
    switch_fault_per_channel_fault_regs_reporting u_switch_fault_per_channel_fault_regs_reporting (.i_ref_clk(ref_clk),
        .i_reset(reset), .i_raw(raw), .i_switch_on_command_bits(cmd),
        .i_fault_mask_load(mload), .i_fault_pin_mask(mval), .i_auto_clear_load(aload),
        .i_auto_clear_mask(aval), .i_report_clear_request(clr), .o_global_fault_summary(sm),
        .o_channel_overheat_constraint(ot), .o_channel_overcurrent_shutdown(oc),
        .o_out_ctrl(ctl), .o_fault_indicator_pin_out(pin_out),
        .o_fault_indicator_pin_oe(pin_oe));
    host_model u_host_model (.i_ref_clk(ref_clk), .i_pin_oe(pin_oe), .i_pin_out(pin_out),
        .i_clear_go(go), .i_clear_bits(cbits), .o_pin_level(pin), .o_clear(clr));
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // a raw change shows two sync flops, the settle count and two register stages later
    task automatic settle();
        repeat (SETTLE_CYCLES + 6) @(negedge ref_clk);
    endtask
    task automatic clear(input logic [11:0] bits);
        @(negedge ref_clk);
        cbits <= bits;
        go <= 1'b1;
        @(negedge ref_clk);
        go <= 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // watchdog: the sequence needs about 3000 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        check("reset", {sm, pin, 3'h0}, 12'h008);
        // the four supply states: field value equals the table index
        for (int i = 0; i < 4; i++) begin
            {raw.field_supply_over, raw.field_supply_low, raw.field_supply_under} = sup[i];
            settle();
            check("supply field", 12'(sm[5:4]), 12'(i));
            check("link loss", 12'(sm[7]), 12'(i == 3));
            check("fault pin", 12'(pin), 12'(i < 2));
            check("channels", 12'(ctl.channel_on), (i == 3) ? 12'h000 : 12'h00f);
            check("clamp", 12'(ctl.low_clamp), 12'(i == 2));
        end
        raw = '0;
        settle();
        clear(12'hfff);
        check("recovered", {sm, ctl.channel_on}, 12'h00f);
        // a short swing must leave the report unchanged
        raw.field_supply_over = 1'b1;
        repeat (100) @(negedge ref_clk);
        raw.field_supply_over = 1'b0;
        settle();
        check("swing", 12'(sm), 12'h000);
        raw.overheat = 4'h2;
        settle();
        check("hot one", {ot, ctl.channel_on, 3'(ctl.low_clamp), pin}, 12'h2d2);
        check("no global", 12'(sm[6]), 12'h000);
        raw.overheat = 4'hf;
        settle();
        check("hot all", {ot, ctl.channel_on, 3'(sm[6]), pin}, 12'hf02);
        raw.overheat = 4'h0;
        cmd = 4'he;
        raw.overcurrent = 4'h3;
        settle();
        check("overload", {oc, ctl.channel_on, 3'h0, pin}, 12'h2c0);
        raw.overcurrent = 4'h0;
        cmd = 4'hf;
        settle();
        check("released", {ot, ctl.channel_on, 4'h0}, 12'h0f0);
        // host makes the warning a pin fault and holds its report
        @(negedge ref_clk);
        {mval, aval, mload, aload} = {12'hfff, 12'hbff, 2'h3};
        @(negedge ref_clk);
        {mload, aload} = 2'h0;
        raw.field_supply_low = 1'b1;
        settle();
        clear(12'h400);
        check("warn kept", {7'(sm[4]), 4'h0, pin}, 12'h020);
        raw.field_supply_low = 1'b0;
        settle();
        check("warn held", {7'(sm[4]), 4'h0, pin}, 12'h020);
        clear(12'h400);
        check("warn gone", {sm, 3'h0, pin}, 12'h001);
        raw.logic_supply_low = 1'b1;
        settle();
        check("logic low", {sm, ctl.channel_on}, 12'h000);
        check("logic pin", 12'(pin), 12'h000);
        raw.logic_supply_low = 1'b0;
        settle();
        check("logic back", {7'h0, ctl.channel_on, pin}, 12'h01f);
        print_verdict();
    end
endmodule
`default_nettype wire
